// ### config_security_lock.sv
/*
  Security gate for the on-chip configuration flash: decryption key and
  protect key storage, lock fuses, permission checks for erase, program
  and readback, and acceptance of encrypted configuration data.
  Assumes: fuse image held outside (nv_* ports, captured after reset),
  decryption and CRC engines outside, from_jtag marks bus accesses that
  arrive through the JTAG port.
*/
// The Avalon-MM interface to the registers and the register addresses are this design's own decisions.
// Summary of operation
// - encrypted configuration accepted only when its key equals stored key
// - decryption key may be loaded only through the JTAG port
// - key-lock fuse plus power cycle hides the stored decryption key
// - readback-inhibit bit refuses readback on configuration and JTAG ports
// - OTP blocks erase and program; security bit blocks readback
// - OTP fuse permanently blocks every write, erase, reprogram, settings
// - with protection on, erase or program needs matching 64-bit key; cfg_valid direct programming here needs no key
// - matching protect key enters programming mode for flash and SRAM
// - protection alone never blocks readback
// - programmer can query whether flash protection is enabled
// - direct flash program: decrypt, check CRC, no done fuse on fail
// - choosing encryption or protection sets the security bit
`timescale 1ns/1ps
module config_security_lock
  import config_security_lock_pkg::*;
#(
  parameter int DKEY_W = DKEY_BITS,
  parameter int PKEY_W = PKEY_BITS
) (
  input wire logic ref_clk, // 100 MHz clock
  input wire logic rst_b, // async reset, active low
  input wire logic [config_security_lock_pkg::ADDR_W-1:0] avs_address, // addr
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [config_security_lock_pkg::DATA_W-1:0] avs_writedata, // wr
  output logic [config_security_lock_pkg::DATA_W-1:0] avs_readdata, // rd data
  output logic avs_waitrequest, // stall
  input wire logic from_jtag, // access arrives via jtag port
  input wire logic nv_secure_in, // fuse image: readback inhibit
  input wire logic nv_otp_in, // fuse image: otp lock
  input wire logic nv_klock_in, // fuse image: key lock
  input wire logic nv_prot_in, // fuse image: protection on
  input wire logic nv_dkey_set_in, // fuse image: key programmed
  input wire logic nv_done_in, // fuse image: done fuse
  input wire logic [DKEY_W-1:0] nv_dkey_in, // fuse image: decryption key
  input wire logic [PKEY_W-1:0] nv_pkey_in, // fuse image: protect key
  output logic nv_secure_out, // fuse value to store
  output logic nv_otp_out, // fuse value to store
  output logic nv_klock_out, // fuse value to store
  output logic nv_prot_out, // fuse value to store
  output logic nv_dkey_set_out, // fuse value to store
  output logic nv_done_out, // done fuse
  output logic [DKEY_W-1:0] nv_dkey_out, // key to store
  output logic [PKEY_W-1:0] nv_pkey_out, // protect key to store
  input wire logic cfg_valid, // one-cycle: config image checked
  input wire logic cfg_encrypted, // image was encrypted
  input wire logic [DKEY_W-1:0] cfg_key, // key the image was made with
  input wire logic cfg_crc_ok, // all crc checks passed
  output logic cfg_accept, // pulse: configuration accepted
  output logic flash_erase, // pulse: erase granted
  output logic flash_program, // pulse: program granted
  output logic readback_grant, // pulse: readback granted
  output logic prog_mode // programming mode (flash and sram)
);

  // ------------------------------------------------------------
  // elaboration check
  // ------------------------------------------------------------
  if (DKEY_W != DKEY_BITS || PKEY_W != PKEY_BITS) begin : g_bad
    $error("key widths must match the 4-word and 2-word register map");
  end

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    S_LOAD = 3'b001,
    S_IDLE = 3'b010,
    S_PROG = 3'b100
  } mode_e;

  typedef struct packed {
    mode_e st;
    logic [DKEY_W-1:0] dkey;
    logic [PKEY_W-1:0] pkey;
    logic [DKEY_W-1:0] dk_stg;
    logic [PKEY_W-1:0] pk_stg;
    logic secure;
    logic otp;
    logic klock;
    logic klock_eff;
    logic prot_en;
    logic dkey_set;
    logic done;
    logic cmd_err;
    logic cfg_err;
    logic wait_req;
    logic [DATA_W-1:0] rdata;
    logic cfg_ok_p;
    logic erase_p;
    logic prog_p;
    logic rb_p;
  } state_s;

  state_s r_ff;
  state_s nxt_r;

  // ------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------
  function automatic logic in_dkey(input logic [ADDR_W-1:0] a);
    in_dkey = (a >= OFS_DKEY0) && (a <= OFS_DKEY3) && (a[1:0] == 2'b00);
  endfunction

  function automatic logic [1:0] key_idx(input logic [ADDR_W-1:0] a,
                                          input logic [ADDR_W-1:0] base);
    logic [ADDR_W-1:0] d;
    d = a - base;
    key_idx = d[3:2];
  endfunction

  logic bus_req;
  logic bus_take;
  logic write_ok;
  logic [CMD_W-1:0] cmd;
  logic [DATA_W-1:0] status_word;
  logic [DATA_W-1:0] rd_word;

  assign bus_req = avs_read | avs_write;
  assign bus_take = bus_req & ~r_ff.wait_req;
  assign cmd = avs_writedata[CMD_LSB +: CMD_W];
  // contents may change only without otp, and with protection only
  // inside programming mode
  assign write_ok = ~r_ff.otp & (~r_ff.prot_en | r_ff.st == S_PROG);

  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  always_comb begin
    status_word = ZERO_WORD;
    status_word[ST_PROG_MODE] = (r_ff.st == S_PROG);
    status_word[ST_PROT_EN] = r_ff.prot_en;
    status_word[ST_SECURE] = r_ff.secure;
    status_word[ST_OTP] = r_ff.otp;
    status_word[ST_KLOCK] = r_ff.klock;
    status_word[ST_KLOCK_EFF] = r_ff.klock_eff;
    status_word[ST_DKEY_SET] = r_ff.dkey_set;
    status_word[ST_DONE] = r_ff.done;
    status_word[ST_CMD_ERR] = r_ff.cmd_err;
    status_word[ST_CFG_ERR] = r_ff.cfg_err;
    status_word[ST_LOADING] = (r_ff.st == S_LOAD);
  end

  always_comb begin
    rd_word = ZERO_WORD;
    if (avs_address == OFS_STATUS) begin
      rd_word = status_word;
    end else if (in_dkey(avs_address)) begin
      // stored key hidden once lock is in force, and off the jtag path
      if (!r_ff.klock_eff && from_jtag) begin
        rd_word = r_ff.dkey[key_idx(avs_address, OFS_DKEY0)*DATA_W +: DATA_W];
      end
    end
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    nxt_r = r_ff;
    nxt_r.cfg_ok_p = 1'b0;
    nxt_r.erase_p = 1'b0;
    nxt_r.prog_p = 1'b0;
    nxt_r.rb_p = 1'b0;

    // one wait state, then the answer edge
    if (r_ff.st == S_LOAD) begin
      nxt_r.wait_req = 1'b1;
    end else if (bus_req && r_ff.wait_req) begin
      nxt_r.wait_req = 1'b0;
      nxt_r.rdata = avs_read ? rd_word : ZERO_WORD;
    end else begin
      nxt_r.wait_req = 1'b1;
    end

    case (r_ff.st)
      S_LOAD: begin
        // fuse image captured on the first edge after reset release
        nxt_r.secure = nv_secure_in;
        nxt_r.otp = nv_otp_in;
        nxt_r.klock = nv_klock_in;
        nxt_r.klock_eff = nv_klock_in;
        nxt_r.prot_en = nv_prot_in;
        nxt_r.dkey_set = nv_dkey_set_in;
        nxt_r.done = nv_done_in;
        nxt_r.dkey = nv_dkey_in;
        nxt_r.pkey = nv_pkey_in;
        nxt_r.st = S_IDLE;
      end
      S_IDLE, S_PROG: begin
        if (bus_take && avs_write) begin
          if (in_dkey(avs_address)) begin
            nxt_r.dk_stg[key_idx(avs_address, OFS_DKEY0)*DATA_W +: DATA_W] =
              avs_writedata;
          end else if (avs_address == OFS_PKEY0 ||
                       avs_address == OFS_PKEY1) begin
            nxt_r.pk_stg[key_idx(avs_address, OFS_PKEY0)*DATA_W +: DATA_W] =
              avs_writedata;
          end else if (avs_address == OFS_CTRL) begin
            nxt_r.cmd_err = 1'b0;
            case (cmd)
              CMD_LOAD_DKEY: begin
                if (write_ok && from_jtag) begin
                  nxt_r.dkey = r_ff.dk_stg;
                  nxt_r.dkey_set = 1'b1;
                  nxt_r.secure = 1'b1;
                end else begin
                  nxt_r.cmd_err = 1'b1;
                end
              end
              CMD_LOAD_PKEY: begin
                if (write_ok) begin
                  nxt_r.pkey = r_ff.pk_stg;
                  nxt_r.prot_en = 1'b1;
                  nxt_r.secure = 1'b1;
                end else begin
                  nxt_r.cmd_err = 1'b1;
                end
              end
              CMD_SET_SECURE: begin
                if (write_ok) begin
                  nxt_r.secure = 1'b1;
                end else begin
                  nxt_r.cmd_err = 1'b1;
                end
              end
              CMD_SET_OTP: begin
                if (write_ok) begin
                  nxt_r.otp = 1'b1;
                  nxt_r.st = S_IDLE;
                end else begin
                  nxt_r.cmd_err = 1'b1;
                end
              end
              CMD_SET_KLOCK: begin
                // takes effect on the key only after the next power-up
                if (write_ok) begin
                  nxt_r.klock = 1'b1;
                end else begin
                  nxt_r.cmd_err = 1'b1;
                end
              end
              CMD_UNLOCK: begin
                if (r_ff.otp) begin
                  nxt_r.cmd_err = 1'b1;
                end else if (!r_ff.prot_en ||
                             r_ff.pk_stg == r_ff.pkey) begin
                  nxt_r.st = S_PROG;
                end else begin
                  nxt_r.cmd_err = 1'b1;
                end
              end
              CMD_ERASE: begin
                if (write_ok) begin
                  nxt_r.erase_p = 1'b1;
                  nxt_r.done = 1'b0;
                end else begin
                  nxt_r.cmd_err = 1'b1;
                end
              end
              CMD_PROGRAM: begin
                if (write_ok) begin
                  nxt_r.prog_p = 1'b1;
                end else begin
                  nxt_r.cmd_err = 1'b1;
                end
              end
              CMD_READBACK: begin
                // only the security bit gates readback, on either port
                if (!r_ff.secure) begin
                  nxt_r.rb_p = 1'b1;
                end else begin
                  nxt_r.cmd_err = 1'b1;
                end
              end
              CMD_EXIT: begin
                nxt_r.st = S_IDLE;
              end
              default: begin
                nxt_r.cmd_err = 1'b1;
              end
            endcase
          end
        end

        // direct flash programming of a decrypted, crc-checked image
        if (cfg_valid) begin
          if (r_ff.otp ||
              (cfg_encrypted && (!r_ff.dkey_set ||
                                 cfg_key != r_ff.dkey))) begin
            nxt_r.cfg_err = 1'b1;
          end else if (!cfg_crc_ok) begin
            nxt_r.cfg_err = 1'b1;
          end else begin
            nxt_r.cfg_err = 1'b0;
            nxt_r.done = 1'b1;
            nxt_r.cfg_ok_p = 1'b1;
          end
        end
      end
      default: begin
        nxt_r.st = S_LOAD;
      end
    endcase
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      r_ff <= '{st: S_LOAD, wait_req: 1'b1, default: '0};
    end else begin
      r_ff <= nxt_r;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign avs_readdata = r_ff.rdata;
  assign avs_waitrequest = r_ff.wait_req;
  assign nv_secure_out = r_ff.secure;
  assign nv_otp_out = r_ff.otp;
  assign nv_klock_out = r_ff.klock;
  assign nv_prot_out = r_ff.prot_en;
  assign nv_dkey_set_out = r_ff.dkey_set;
  assign nv_done_out = r_ff.done;
  assign nv_dkey_out = r_ff.dkey;
  assign nv_pkey_out = r_ff.pkey;
  assign cfg_accept = r_ff.cfg_ok_p;
  assign flash_erase = r_ff.erase_p;
  assign flash_program = r_ff.prog_p;
  assign readback_grant = r_ff.rb_p;
  assign prog_mode = (r_ff.st == S_PROG);

endmodule

// ### config_security_lock_pkg.sv
/*
  Shared constants for the configuration security gate: register byte
  offsets, command codes, status bit positions and key widths.
  Assumes an Avalon-MM bus with 32-bit data and byte addresses.
*/
package config_security_lock_pkg;

  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int DKEY_BITS = 128;
  localparam int PKEY_BITS = 64;

  // ------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_DKEY0 = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_DKEY3 = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_PKEY0 = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_PKEY1 = 8'h1c;

  // ------------------------------------------------------------
  // command field of the control register
  // ------------------------------------------------------------
  localparam int CMD_LSB = 0;
  localparam int CMD_W = 4;
  localparam logic [CMD_W-1:0] CMD_LOAD_DKEY = 4'h1;
  localparam logic [CMD_W-1:0] CMD_LOAD_PKEY = 4'h2;
  localparam logic [CMD_W-1:0] CMD_SET_SECURE = 4'h3;
  localparam logic [CMD_W-1:0] CMD_SET_OTP = 4'h4;
  localparam logic [CMD_W-1:0] CMD_SET_KLOCK = 4'h5;
  localparam logic [CMD_W-1:0] CMD_UNLOCK = 4'h6;
  localparam logic [CMD_W-1:0] CMD_ERASE = 4'h7;
  localparam logic [CMD_W-1:0] CMD_PROGRAM = 4'h8;
  localparam logic [CMD_W-1:0] CMD_READBACK = 4'h9;
  localparam logic [CMD_W-1:0] CMD_EXIT = 4'ha;

  // ------------------------------------------------------------
  // status register bit positions
  // ------------------------------------------------------------
  localparam int ST_PROG_MODE = 0;
  localparam int ST_PROT_EN = 1;
  localparam int ST_SECURE = 2;
  localparam int ST_OTP = 3;
  localparam int ST_KLOCK = 4;
  localparam int ST_KLOCK_EFF = 5;
  localparam int ST_DKEY_SET = 6;
  localparam int ST_DONE = 7;
  localparam int ST_CMD_ERR = 8;
  localparam int ST_CFG_ERR = 9;
  localparam int ST_LOADING = 10;

  localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;

endpackage

// ### config_security_lock_checker.sv
/* port checker for the configuration security gate
   assumes: bound onto every config_security_lock instance */
`timescale 1ns/1ps
module config_security_lock_checker
  import config_security_lock_pkg::*;
#(
  parameter int DKEY_W = DKEY_BITS,
  parameter int PKEY_W = PKEY_BITS
) (
  input wire logic ref_clk, // clock
  input wire logic rst_b, // reset
  input wire logic [ADDR_W-1:0] avs_address, // address
  input wire logic avs_read, // read
  input wire logic avs_write, // write
  input wire logic [DATA_W-1:0] avs_readdata, // read data
  input wire logic avs_waitrequest, // stall
  input wire logic from_jtag, // jtag path
  input wire logic nv_secure_out, // inhibit fuse
  input wire logic nv_otp_out, // otp fuse
  input wire logic nv_prot_out, // protect fuse
  input wire logic [DKEY_W-1:0] nv_dkey_out, // stored key
  input wire logic [PKEY_W-1:0] nv_pkey_out, // protect key
  input wire logic cfg_valid, // image checked
  input wire logic cfg_encrypted, // encrypted
  input wire logic [DKEY_W-1:0] cfg_key, // image key
  input wire logic cfg_crc_ok, // crc good
  input wire logic cfg_accept, // accepted
  input wire logic flash_erase, // erase
  input wire logic flash_program, // program
  input wire logic readback_grant, // readback
  input wire logic prog_mode // unlocked
);
  // ------------------------------------------------------------
  // bus and permission properties
  // ------------------------------------------------------------
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);

  sequence key_read;
    avs_read && !from_jtag && avs_address inside {[OFS_DKEY0:OFS_DKEY3]}
      && avs_waitrequest ##1 !avs_waitrequest;
  endsequence
  sequence stat_read;
    avs_read && avs_address == OFS_STATUS && avs_waitrequest
      ##1 !avs_waitrequest;
  endsequence

  wait_single_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest
    |-> ##[1:2] !avs_waitrequest) else $error("bus not answered");
  key_hidden_a: assert property (key_read |-> avs_readdata == ZERO_WORD)
    else $error("key visible off jtag");
  cfg_key_a: assert property (cfg_valid && cfg_encrypted &&
    cfg_key != nv_dkey_out |=> !cfg_accept) else $error("wrong key taken");
  cfg_crc_a: assert property (cfg_valid && !cfg_crc_ok |=> !cfg_accept)
    else $error("bad crc taken");
  otp_block_a: assert property (nv_otp_out |=>
    !(flash_erase || flash_program || cfg_accept)) else $error("otp open");
  otp_hold_a: assert property (nv_otp_out |=> nv_otp_out &&
    $stable(nv_dkey_out) && $stable(nv_pkey_out) && $stable(nv_prot_out))
    else $error("otp contents changed");
  sec_rb_a: assert property (nv_secure_out |=> !readback_grant)
    else $error("readback while inhibited");
  prot_gate_a: assert property (nv_prot_out &&
    (flash_erase || flash_program) |-> prog_mode) else $error("not unlocked");
  prot_read_a: assert property (stat_read |->
    avs_readdata[ST_PROT_EN] == nv_prot_out) else $error("protect bit");
endmodule

bind config_security_lock config_security_lock_checker #(
  .DKEY_W(DKEY_W),
  .PKEY_W(PKEY_W)
) chk_inst (
  .ref_clk, .rst_b, .avs_address, .avs_read, .avs_write, .avs_readdata,
  .avs_waitrequest, .from_jtag, .nv_secure_out, .nv_otp_out, .nv_prot_out,
  .nv_dkey_out, .nv_pkey_out, .cfg_valid, .cfg_encrypted, .cfg_key,
  .cfg_crc_ok, .cfg_accept, .flash_erase, .flash_program, .readback_grant,
  .prog_mode
);

// ### jtag_programmer.sv
/* programmer model: bus master on the cable side of the gate
   assumes: one clock shared with the gate, bench calls xfer */
`timescale 1ns/1ps
module jtag_programmer
  import config_security_lock_pkg::*;
(
  input wire logic ref_clk, // clock
  output logic [ADDR_W-1:0] avs_address, // address
  output logic avs_read, // read
  output logic avs_write, // write
  output logic [DATA_W-1:0] avs_writedata, // write data
  input wire logic [DATA_W-1:0] avs_readdata, // read data
  input wire logic avs_waitrequest, // stall
  output logic from_jtag // jtag path
);
  // ------------------------------------------------------------
  // one bus access, random idle gap first
  // ------------------------------------------------------------
  initial begin
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = ZERO_WORD;
    from_jtag = 1'b0;
  end

  task automatic xfer(input logic wr, input logic jt,
      input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
      output logic [DATA_W-1:0] q, output logic ok);
    int n;
    n = $urandom_range(2, 0);
    repeat (n + 1) @(posedge ref_clk);
    from_jtag <= jt;
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    q = avs_readdata;
    ok = n < 40;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    avs_address <= ~a;
    avs_writedata <= ~d;
  endtask
endmodule

// ### testbench.sv
/* self-checking bench: reference model of locks, keys and pulses
   assumes: programmer model drives the bus, fuses persist by copy */
`timescale 1ns/1ps
module testbench;
  import config_security_lock_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [ADDR_W-1:0] avs_address;
  logic avs_read, avs_write, from_jtag, avs_waitrequest;
  logic [DATA_W-1:0] avs_writedata, avs_readdata, q;
  logic sec_i, otp_i, kl_i, prot_i, dks_i, done_i;
  logic sec_o, otp_o, kl_o, prot_o, dks_o, done_o;
  logic [127:0] dkey_i, dkey_o, dkey, dst, k;
  logic [127:0] cfg_key = 128'h0;
  logic [63:0] pkey_i, pkey_o, pkey, pst, p;
  logic cfg_valid = 1'b0, cfg_encrypted = 1'b0, cfg_crc_ok = 1'b0;
  logic cfg_accept, flash_erase, flash_program, readback_grant, prog_mode;
  logic m_sec, m_otp, m_prot, m_kl, m_kle, m_dks, m_done, m_pm, m_err, m_cfe;
  int fail_count = 0, check_count = 0;
  int n_er = 0, n_pg = 0, n_rb = 0, n_ac = 0;
  int e_er = 0, e_pg = 0, e_rb = 0, e_ac = 0;
  logic [3:0] ops [5] = '{CMD_SET_SECURE, CMD_SET_OTP, CMD_PROGRAM,
    CMD_LOAD_PKEY, CMD_UNLOCK};

  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    if (flash_erase === 1'b1) n_er++;
    if (flash_program === 1'b1) n_pg++;
    if (readback_grant === 1'b1) n_rb++;
    if (cfg_accept === 1'b1) n_ac++;
  end

  config_security_lock config_security_lock_inst (
    .ref_clk, .rst_b, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .from_jtag,
    .nv_secure_in(sec_i), .nv_otp_in(otp_i), .nv_klock_in(kl_i),
    .nv_prot_in(prot_i), .nv_dkey_set_in(dks_i), .nv_done_in(done_i),
    .nv_dkey_in(dkey_i), .nv_pkey_in(pkey_i),
    .nv_secure_out(sec_o), .nv_otp_out(otp_o), .nv_klock_out(kl_o),
    .nv_prot_out(prot_o), .nv_dkey_set_out(dks_o), .nv_done_out(done_o),
    .nv_dkey_out(dkey_o), .nv_pkey_out(pkey_o),
    .cfg_valid, .cfg_encrypted, .cfg_key, .cfg_crc_ok, .cfg_accept,
    .flash_erase, .flash_program, .readback_grant, .prog_mode);
  jtag_programmer jtag_programmer_inst (.ref_clk, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .from_jtag);

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [127:0] s, e);
    check_count++;
    if (s !== e) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic acc(input logic wr, jt, input logic [7:0] a,
      input logic [31:0] d);
    logic ok;
    jtag_programmer_inst.xfer(wr, jt, a, d, q, ok);
    if (ok !== 1'b1) begin
      fail_count++;
      end_of_test();
    end
  endtask

  // power cycle: image is either the stored fuses or a forced pattern
  task automatic pwr(input logic ovr, input logic [2:0] f);
    @(posedge ref_clk);
    rst_b <= 1'b0;
    {sec_i, otp_i, prot_i, kl_i, dks_i, done_i, dkey_i, pkey_i} <= ovr ?
      {f, 195'h0} : {sec_o, otp_o, prot_o, kl_o, dks_o, done_o, dkey_o, pkey_o};
    repeat (20) @(posedge ref_clk);
    rst_b <= 1'b1;
    {m_sec, m_otp, m_prot, m_kl, m_dks, m_done, dkey, pkey} =
      {sec_i, otp_i, prot_i, kl_i, dks_i, done_i, dkey_i, pkey_i};
    {m_kle, m_pm, m_err, m_cfe} = {m_kl, 3'b000};
  endtask

  task automatic status();
    acc(1'b0, 1'b0, OFS_STATUS, ZERO_WORD);
    chk("status", q, {22'h0, m_cfe, m_err, m_done, m_dks, m_kle,
      m_kl, m_otp, m_sec, m_prot, m_pm});
    chk("fuses", {sec_o, otp_o, prot_o, kl_o, dks_o, done_o, prog_mode,
      pkey_o}, {m_sec, m_otp, m_prot, m_kl, m_dks, m_done, m_pm, pkey});
    chk("dkey out", dkey_o, dkey);
    chk("pulses", {n_er, n_pg, n_rb, n_ac}, {e_er, e_pg, e_rb, e_ac});
  endtask

  task automatic cmd(input logic [3:0] c, input logic jt);
    acc(1'b1, jt, OFS_CTRL, {28'h0, c});
    m_err = 1'b0;
    if (c inside {[4'h1:4'h5], 4'h7, 4'h8} && (m_otp || (m_prot && !m_pm)))
      m_err = 1'b1;
    else case (c)
      CMD_LOAD_DKEY: if (jt) {m_dks, m_sec, dkey} = {2'b11, dst};
        else m_err = 1'b1;
      CMD_LOAD_PKEY: {m_prot, m_sec, pkey} = {2'b11, pst};
      CMD_SET_SECURE: m_sec = 1'b1;
      CMD_SET_OTP: m_otp = 1'b1;
      CMD_SET_KLOCK: m_kl = 1'b1;
      CMD_UNLOCK: if (m_otp || (m_prot && pst !== pkey)) m_err = 1'b1;
        else m_pm = 1'b1;
      CMD_ERASE: {e_er, m_done} = {e_er + 1, 1'b0};
      CMD_PROGRAM: e_pg++;
      CMD_READBACK: if (m_sec) m_err = 1'b1;
        else e_rb++;
      CMD_EXIT: m_pm = 1'b0;
      default: m_err = 1'b1;
    endcase
    status();
  endtask

  task automatic stage(input logic [127:0] dk, input logic [63:0] pk);
    for (int i = 0; i < 4; i++)
      acc(1'b1, 1'b1, OFS_DKEY0 + 8'(4 * i), dk[32 * i +: 32]);
    acc(1'b1, 1'b1, OFS_PKEY0, pk[31:0]);
    acc(1'b1, 1'b1, OFS_PKEY1, pk[63:32]);
    {dst, pst} = {dk, pk};
  endtask

  task automatic keyrd(input logic jt);
    for (int i = 0; i < 4; i++) begin
      acc(1'b0, jt, OFS_DKEY0 + 8'(4 * i), ZERO_WORD);
      chk("dkey", q, jt && !m_kle ? dkey[32 * i +: 32] : 32'h0);
    end
  endtask

  task automatic cfg(input logic enc, input logic [127:0] ck, input logic c);
    @(posedge ref_clk);
    {cfg_valid, cfg_encrypted, cfg_key, cfg_crc_ok} <= {1'b1, enc, ck, c};
    @(posedge ref_clk);
    {cfg_valid, cfg_key} <= {1'b0, ~ck};
    m_cfe = 1'b1;
    if (!m_otp && c && (!enc || (m_dks && ck === dkey)))
      {e_ac, m_done, m_cfe} = {e_ac + 1, 2'b10};
    status();
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(32'h1d97f389));
    pwr(1'b1, 3'b000);
    acc(1'b0, 1'b1, 8'h40, ZERO_WORD);
    chk("unmapped", q, ZERO_WORD);
    k = {$urandom, $urandom, $urandom, $urandom};
    p = {$urandom, $urandom};
    if (p === k[63:0]) p = ~p;
    stage(k, p);
    cmd(CMD_LOAD_DKEY, 1'b0);
    cmd(CMD_LOAD_DKEY, 1'b1);
    keyrd(1'b1);
    keyrd(1'b0);
    cmd(CMD_LOAD_PKEY, 1'b1);
    cmd(CMD_ERASE, 1'b1);
    cmd(CMD_READBACK, 1'b1);
    stage(k, p ^ (64'h1 << $urandom_range(63, 0)));
    cmd(CMD_UNLOCK, 1'b1);
    stage(k, p);
    cmd(CMD_UNLOCK, 1'b1);
    cmd(4'hf, 1'b1);
    cmd(CMD_ERASE, 1'b1);
    cmd(CMD_PROGRAM, 1'b1);
    cfg(1'b1, k ^ 128'h1, 1'b1);
    cfg(1'b1, k, 1'b0);
    cfg(1'b1, k, 1'b1);
    cmd(CMD_SET_KLOCK, 1'b1);
    cmd(CMD_EXIT, 1'b1);
    pwr(1'b0, 3'b000);
    keyrd(1'b1);
    for (int i = 0; i < 4; i++) begin
      pwr(1'b1, {i[1], i[0], 1'b0});
      cmd(CMD_READBACK, 1'b1);
      cmd(CMD_ERASE, 1'b1);
    end
    pwr(1'b1, 3'b001);
    cmd(CMD_READBACK, 1'b1);
    cmd(CMD_PROGRAM, 1'b1);
    pwr(1'b1, 3'b000);
    foreach (ops[i]) cmd(ops[i], 1'b1);
    cfg(1'b0, k, 1'b1);
    end_of_test();
  end
endmodule
